// [hw/irq_flag_bank.sv]
`timescale 1ns/10ps
`default_nettype none

`include "pmic_irq_defs.svh"

// ****************************************************************
// Bank of sticky flags, cleared as a group, where a set always wins.
// ****************************************************************
module irq_flag_bank
  import pmic_irq_pkg::*;
#(
  parameter int WIDTH = `IRQ_FIELD_W
) (
  input wire logic i_clk,               // Core clock.
  input wire logic i_rst_n,             // Synchronised reset, active low.
  input wire logic [WIDTH-1:0] i_set,   // Set requests, one per flag.
  input wire logic i_clear,             // Clear all flags, one cycle.
  output logic [WIDTH-1:0] o_flags      // Flag state.
);

  logic [WIDTH-1:0] flags_d;
  logic [WIDTH-1:0] flags_q;

  // A set in the clearing cycle survives, so no event is ever lost.
  always_comb begin
    flags_d = i_set | (flags_q & ~{WIDTH{i_clear}});
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;

endmodule

`default_nettype wire

// [hw/pmic_irq_defs.svh]
`ifndef PMIC_IRQ_DEFS_SVH
`define PMIC_IRQ_DEFS_SVH

// ****************************************************************
// Register map of the interrupt block.
// ****************************************************************
`define ADDR_W 8
`define DATA_W 8
`define SYS_IRQ_FLAGS_ADDR 8'h01
`define LSW_IRQ_FLAGS_ADDR 8'h02
`define SYS_IRQ_MASK_ADDR 8'h03
`define LSW_IRQ_MASK_ADDR 8'h04

// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define IRQ_FIELD_W 6
`define IRQ_RESET 6'h00
`define READ_RESET 8'h00

// Load-switch flag positions.
`define SW3_FAULT_BIT 5
`define SW2_FAULT_BIT 4
`define SW1_FAULT_BIT 3
`define SW3_ILIMIT_BIT 2
`define SW2_ILIMIT_BIT 1
`define SW1_ILIMIT_BIT 0

// System source positions, shared by flags and mask.
`define PROG_VOLTAGE_BIT 5
`define MAINS_DETECT_BIT 4
`define BUTTON_CHANGE_BIT 3
`define OVER_TEMP_WARN_BIT 2
`define BACKUP_CELL_ACQ_BIT 1
`define PROG_COMPLETE_BIT 0

`endif

// [hw/pmic_irq_flags_and_masks.sv]
// Functional notes
// - Load-switch flags at 0x2 are read-only, reset to 0, bits 7:6 read 0.
// - Bit 5 reads 1 while switch three is off for over-temperature, else 0.
// - Bit 4 reads 1 while switch two is off for overheat or low input.
// - Bit 3 reads 1 while switch one is off for over-temperature, else 0.
// - Bits 2..0 read 1 while switches three..one limit current, else 0.
// - System mask at 0x3 resets to 0, bits 5:0 read/write, bits 7:6 read 0.
// - A mask bit of 0 lets its source pull the interrupt output low.
// - A mask bit of 1 keeps its source off the interrupt output.
// - Masking never changes how flags are set or updated.
// - Mask bits: prog voltage 5, mains 4, button 3, heat 2, cell 1, done 0.
// - Load-switch mask: fault masks at 5..3, current-limit masks at 2..0.
// - The button flag sets on either edge of its input; mask bit 3 gates only its path to the interrupt output.
`timescale 1ns/10ps
`default_nettype none

`include "pmic_irq_defs.svh"

module pmic_irq_flags_and_masks
  import pmic_irq_pkg::*;
(
  input wire logic i_core_clk,               // Core clock, 25 MHz.
  input wire logic i_resetn,                 // Async reset, active low.
  input wire reg_req_s i_reg_req,            // Decoded register access.
  input wire lsw_status_s i_lsw_status,      // Load-switch conditions.
  input wire sys_source_s i_sys_source,      // System interrupt sources.
  output logic [`DATA_W-1:0] o_reg_rdata,    // Read data, registered.
  output logic o_reg_rvalid,                 // Read data valid pulse.
  output logic o_irq_out_n                   // Interrupt output, low active.
);

  // ****************************************************************
  // Reset release.
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n;

  // Assert at once, release two clean edges later.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic irq_pending(input irq_vec_t flags,
                                       input irq_vec_t mask);
    irq_pending = |(flags & ~mask);
  endfunction

  function automatic logic addr_hit(input reg_req_s req,
                                    input logic [`ADDR_W-1:0] addr);
    addr_hit = (req.addr == addr);
  endfunction

  // ****************************************************************
  // Source edge detection.
  // ****************************************************************
  logic mains_prev_d;
  logic mains_prev_q;
  logic button_prev_d;
  logic button_prev_q;
  logic prev_valid_d;
  logic prev_valid_q;
  logic mains_change;
  logic button_change;

  // The previous-level copies are trusted only after one sample, so a
  // pin that sits high out of reset is not taken for an edge.
  always_comb begin
    mains_prev_d = i_sys_source.mains_detect_input;
    button_prev_d = i_sys_source.button_input;
    prev_valid_d = 1'b1;
    mains_change = prev_valid_q &&
      (i_sys_source.mains_detect_input != mains_prev_q);
    button_change = prev_valid_q &&
      (i_sys_source.button_input != button_prev_q);
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mains_prev_q <= 1'b0;
      button_prev_q <= 1'b0;
      prev_valid_q <= 1'b0;
    end else begin
      mains_prev_q <= mains_prev_d;
      button_prev_q <= button_prev_d;
      prev_valid_q <= prev_valid_d;
    end
  end

  // ****************************************************************
  // Flag set vectors.
  // ****************************************************************
  irq_vec_t lsw_set;
  irq_vec_t sys_set;
  logic rd_lsw_flags;
  logic rd_sys_flags;

  // Level conditions set every cycle they stand, so a flag reads 1 while
  // its condition holds and drops at the first read after it ends.
  // The masks take no part here: monitoring runs the same either way.
  always_comb begin
    lsw_set = '0;
    lsw_set[`SW3_FAULT_BIT] = i_lsw_status.overtemp[2];
    lsw_set[`SW2_FAULT_BIT] = i_lsw_status.overtemp[1] |
                              i_lsw_status.sw2_undervolt;
    lsw_set[`SW1_FAULT_BIT] = i_lsw_status.overtemp[0];
    lsw_set[`SW3_ILIMIT_BIT] = i_lsw_status.ilimit[2];
    lsw_set[`SW2_ILIMIT_BIT] = i_lsw_status.ilimit[1];
    lsw_set[`SW1_ILIMIT_BIT] = i_lsw_status.ilimit[0];
    sys_set = '0;
    sys_set[`PROG_VOLTAGE_BIT] = i_sys_source.prog_voltage_low;
    sys_set[`MAINS_DETECT_BIT] = mains_change;
    sys_set[`BUTTON_CHANGE_BIT] = button_change;
    sys_set[`OVER_TEMP_WARN_BIT] = i_sys_source.over_temp_warn;
    sys_set[`BACKUP_CELL_ACQ_BIT] = i_sys_source.backup_cell_acq_done;
    sys_set[`PROG_COMPLETE_BIT] = i_sys_source.prog_done;
    rd_lsw_flags = i_reg_req.rd && addr_hit(i_reg_req, `LSW_IRQ_FLAGS_ADDR);
    rd_sys_flags = i_reg_req.rd && addr_hit(i_reg_req, `SYS_IRQ_FLAGS_ADDR);
  end

  irq_vec_t lsw_flags;
  irq_vec_t sys_flags;

  irq_flag_bank #(.WIDTH(`IRQ_FIELD_W)) u_lsw_flags (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_set(lsw_set),
    .i_clear(rd_lsw_flags),
    .o_flags(lsw_flags)
  );

  irq_flag_bank #(.WIDTH(`IRQ_FIELD_W)) u_sys_flags (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_set(sys_set),
    .i_clear(rd_sys_flags),
    .o_flags(sys_flags)
  );

  // ****************************************************************
  // Registers, read port and interrupt output.
  // ****************************************************************
  irq_vec_t sys_mask_d;
  irq_vec_t sys_mask_q;
  irq_vec_t lsw_mask_d;
  irq_vec_t lsw_mask_q;
  logic [`DATA_W-1:0] rdata_d;
  logic rvalid_d;
  logic irq_n_d;

  // Writes to flag registers and unmapped addresses are ignored; reads of
  // unmapped addresses return zero. Upper bits always read as zero.
  always_comb begin
    sys_mask_d = sys_mask_q;
    lsw_mask_d = lsw_mask_q;
    if (i_reg_req.wr && addr_hit(i_reg_req, `SYS_IRQ_MASK_ADDR)) begin
      sys_mask_d = i_reg_req.wdata[`IRQ_FIELD_W-1:0];
    end
    if (i_reg_req.wr && addr_hit(i_reg_req, `LSW_IRQ_MASK_ADDR)) begin
      lsw_mask_d = i_reg_req.wdata[`IRQ_FIELD_W-1:0];
    end
    rdata_d = `READ_RESET;
    case (i_reg_req.addr)
      `SYS_IRQ_FLAGS_ADDR: rdata_d[`IRQ_FIELD_W-1:0] = sys_flags;
      `LSW_IRQ_FLAGS_ADDR: rdata_d[`IRQ_FIELD_W-1:0] = lsw_flags;
      `SYS_IRQ_MASK_ADDR: rdata_d[`IRQ_FIELD_W-1:0] = sys_mask_q;
      `LSW_IRQ_MASK_ADDR: rdata_d[`IRQ_FIELD_W-1:0] = lsw_mask_q;
      default: rdata_d = `READ_RESET;
    endcase
    if (!i_reg_req.rd) begin
      rdata_d = o_reg_rdata;
    end
    rvalid_d = i_reg_req.rd;
    // Only unmasked flags reach the pin.
    irq_n_d = !(irq_pending(sys_flags, sys_mask_q) ||
                irq_pending(lsw_flags, lsw_mask_q));
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_mask_q <= `IRQ_RESET;
      lsw_mask_q <= `IRQ_RESET;
      o_reg_rdata <= `READ_RESET;
      o_reg_rvalid <= 1'b0;
      o_irq_out_n <= 1'b1;
    end else begin
      sys_mask_q <= sys_mask_d;
      lsw_mask_q <= lsw_mask_d;
      o_reg_rdata <= rdata_d;
      o_reg_rvalid <= rvalid_d;
      o_irq_out_n <= irq_n_d;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  AST_IRQ_LOW_UNMASKED: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (|(sys_flags & ~sys_mask_q)) |=> !o_irq_out_n)
    else $error("Unmasked system flag did not pull interrupt low.");

  AST_IRQ_HIGH_MASKED: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (((sys_flags & ~sys_mask_q) == '0) && ((lsw_flags & ~lsw_mask_q) == '0))
    |=> o_irq_out_n)
    else $error("Interrupt low with every set flag masked.");

  AST_IRQ_HOLDS_LOW: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (|(lsw_flags & ~lsw_mask_q)) [*2] |-> !o_irq_out_n [*2])
    else $error("Interrupt released while a flag was pending.");

  AST_RESERVED_ZERO: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    o_reg_rvalid |-> (o_reg_rdata[`DATA_W-1:`IRQ_FIELD_W] == '0))
    else $error("Reserved read bits are not zero.");

  AST_SW3_FAULT: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    i_lsw_status.overtemp[2] |=> lsw_flags[`SW3_FAULT_BIT])
    else $error("Switch three fault flag missing.");

  AST_SW2_FAULT: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (i_lsw_status.overtemp[1] || i_lsw_status.sw2_undervolt)
    |=> lsw_flags[`SW2_FAULT_BIT])
    else $error("Switch two fault flag missing.");

  AST_SW1_FAULT: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    i_lsw_status.overtemp[0] |=> lsw_flags[`SW1_FAULT_BIT])
    else $error("Switch one fault flag missing.");

  AST_ILIMIT: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    1'b1 |=> ((lsw_flags[2:0] & $past(i_lsw_status.ilimit)) ==
              $past(i_lsw_status.ilimit)))
    else $error("Current-limit flag missing.");

  AST_MASK_WRITE: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (i_reg_req.wr && i_reg_req.addr == `SYS_IRQ_MASK_ADDR) |=>
    (sys_mask_q == $past(i_reg_req.wdata[`IRQ_FIELD_W-1:0])))
    else $error("System mask write not stored.");

  AST_BUTTON_MASKED: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (button_change && sys_mask_q[`BUTTON_CHANGE_BIT]) |=>
    sys_flags[`BUTTON_CHANGE_BIT])
    else $error("Masked button change did not set its flag.");

  AST_READ_DATA: assert property (@(posedge i_core_clk)
    disable iff (!rst_n)
    (i_reg_req.rd && i_reg_req.addr == `SYS_IRQ_MASK_ADDR) |=>
    (o_reg_rvalid && o_reg_rdata[`IRQ_FIELD_W-1:0] == $past(sys_mask_q)))
    else $error("Mask read returned wrong data.");

endmodule

`default_nettype wire

// [hw/pmic_irq_pkg.sv]
`default_nettype none

`include "pmic_irq_defs.svh"

package pmic_irq_pkg;

  // Register access as delivered by the serial host interface decoder.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } reg_req_s;

  // Live condition of the three load switches.
  typedef struct packed {
    logic [2:0] overtemp;
    logic sw2_undervolt;
    logic [2:0] ilimit;
  } lsw_status_s;

  // Raw system interrupt sources.
  typedef struct packed {
    logic prog_voltage_low;
    logic mains_detect_input;
    logic button_input;
    logic over_temp_warn;
    logic backup_cell_acq_done;
    logic prog_done;
  } sys_source_s;

  typedef logic [`IRQ_FIELD_W-1:0] irq_vec_t;

endpackage

`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/10ps
`default_nettype none

`include "pmic_irq_defs.svh"

// ****************************************************************
// Host processor on the far side of the decoded register port.
// ****************************************************************
module host_model
  import pmic_irq_pkg::*;
(
  input wire logic i_clk,           // Core clock.
  input wire logic [7:0] i_rdata,   // Read data from the block.
  input wire logic i_rvalid,        // Read data valid pulse.
  output var reg_req_s o_req        // Register request to the block.
);
  // The port is quiet until the first call.
  initial begin
    o_req = '0;
  end

  // One access per call, driven on the falling edge and held over one
  // rising edge. Idle address and data are scrambled so that a stale
  // value can never pass for a fresh one.
  task automatic access(input logic wr, input logic [7:0] addr,
      input logic [7:0] wdata, output logic [7:0] rdata, output logic ok);
    @(negedge i_clk);
    o_req = {~wr, wr, addr, wdata};
    @(negedge i_clk);
    ok = wr | i_rvalid;
    rdata = i_rdata;
    o_req = {2'b00, ~addr, ~wdata};
  endtask

  // Both flag registers are read in turn, system flags first, without waiting on the interrupt.
  task automatic service(output logic [7:0] sys_f, output logic [7:0] lsw_f);
    logic ok;
    access(1'b0, `SYS_IRQ_FLAGS_ADDR, 8'h00, sys_f, ok);
    access(1'b0, `LSW_IRQ_FLAGS_ADDR, 8'h00, lsw_f, ok);
  endtask
endmodule

`default_nettype wire

// [tb/test_pmic_irq_flags_and_masks.sv]
`timescale 1ns/10ps
`default_nettype none

`include "pmic_irq_defs.svh"

module test_pmic_irq_flags_and_masks;
  import pmic_irq_pkg::*;

  // ****************************************************************
  // Signals, clock and instances.
  // ****************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  lsw_status_s lsw;
  sys_source_s src;
  reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic irq_n;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h2A63;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] v;
  logic ok;

  // The clock flips every half period of 20 ns.
  always #20 clk = ~clk;

  pmic_irq_flags_and_masks pmic_irq_flags_and_masks_i (
    .i_core_clk(clk),
    .i_resetn(resetn),
    .i_reg_req(req),
    .i_lsw_status(lsw),
    .i_sys_source(src),
    .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid),
    .o_irq_out_n(irq_n)
  );

  host_model host_model_i (
    .i_clk(clk),
    .i_rdata(rdata),
    .i_rvalid(rvalid),
    .o_req(req)
  );

  // ****************************************************************
  // Helpers for checks and bus traffic.
  // ****************************************************************
  task automatic chk(input string name, input logic [7:0] exp,
      input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A read must also come back with its valid pulse.
  task automatic rd(input logic [7:0] addr);
    host_model_i.access(1'b0, addr, 8'h00, d, ok);
    chk("read valid", 8'h01, {7'h00, ok});
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host_model_i.access(1'b1, addr, data, d2, ok);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Flag image of a load-switch condition vector.
  function automatic logic [7:0] lsw_exp(input lsw_status_s s);
    return {2'b00, s.overtemp[2], s.overtemp[1] | s.sw2_undervolt,
      s.overtemp[0], s.ilimit};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hung handshake is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("timeout after %0d cycles", cycles);
      close_out();
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    lsw = '0;
    src = '0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    cyc(5);
    // Every mapped register starts at zero and the line is released.
    for (int a = 1; a <= 4; a++) begin
      rd(8'(a));
      chk("reset value", 8'h00, d);
    end
    chk("irq at reset", 8'h01, {7'h00, irq_n});
    $display("test reset done");
    // Random mask values; the top two bits never stick.
    repeat (4) begin
      v = 8'($random(seed));
      wr(`SYS_IRQ_MASK_ADDR, v);
      rd(`SYS_IRQ_MASK_ADDR);
      chk("system mask", v & 8'h3F, d);
    end
    wr(`LSW_IRQ_FLAGS_ADDR, 8'hFF);
    rd(`LSW_IRQ_FLAGS_ADDR);
    chk("flags not writable", 8'h00, d);
    rd(8'h07);
    chk("unmapped read", 8'h00, d);
    wr(`SYS_IRQ_MASK_ADDR, 8'h00);
    $display("test masks done");
    // Each switch condition alone, then random mixes, one cycle long.
    for (int i = 0; i < 10; i++) begin
      v = (i < 7) ? 8'h01 << i : 8'($random(seed)) | 8'h01;
      lsw = v[6:0];
      cyc(1);
      lsw = '0;
      cyc(1);
      chk("irq on switch flag", 8'h00, {7'h00, irq_n});
      host_model_i.service(d2, d);
      chk("switch flags", lsw_exp(v[6:0]), d);
      chk("no system flag", 8'h00, d2);
      cyc(1);
      chk("irq released", 8'h01, {7'h00, irq_n});
    end
    // A condition that still stands during a read sets its flag again.
    lsw = 7'h01;
    repeat (2) begin
      rd(`LSW_IRQ_FLAGS_ADDR);
      chk("flag held over read", 8'h01, d);
    end
    lsw = '0;
    rd(`LSW_IRQ_FLAGS_ADDR);
    rd(`LSW_IRQ_FLAGS_ADDR);
    chk("flag after condition", 8'h00, d);
    // Load-switch masks keep the line quiet but not the flags.
    wr(`LSW_IRQ_MASK_ADDR, 8'h3F);
    lsw = 7'h7F;
    cyc(1);
    lsw = '0;
    cyc(2);
    chk("masked switch irq", 8'h01, {7'h00, irq_n});
    rd(`LSW_IRQ_FLAGS_ADDR);
    chk("masked switch flags", 8'h3F, d);
    wr(`LSW_IRQ_MASK_ADDR, 8'h00);
    $display("test switch flags done");
    // Each system source with only its own mask open, then all masked.
    for (int i = 0; i < 6; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(`SYS_IRQ_MASK_ADDR, (m == 1) ? 8'h3F : 8'h3F ^ (8'h01 << i));
        src = sys_source_s'(6'h01 << i);
        cyc(1);
        src = '0;
        cyc(1);
        chk("irq per mask", 8'(m), {7'h00, irq_n});
        cyc(1);
        rd(`SYS_IRQ_FLAGS_ADDR);
        chk("system flag", 8'h01 << i, d);
        cyc(1);
        chk("irq after read", 8'h01, {7'h00, irq_n});
      end
    end
    wr(`SYS_IRQ_MASK_ADDR, 8'h00);
    $display("test system masks done");
    close_out();
  end
endmodule

`default_nettype wire
